// ### hdl/fbad_defs.vh
// constants for the flash base address decode block
`ifndef FBAD_DEFS_VH
`define FBAD_DEFS_VH

// register field positions
`define FBAD_BASE_MSB      31
`define FBAD_BASE_LSB      19
`define FBAD_BACK_DOOR_EN_BIT 9
`define FBAD_WP_BIT        8
`define FBAD_MASK_MSB      5
`define FBAD_MASK_LSB      1
`define FBAD_EN_BIT        0
`define FBAD_MASK_W        5
`define FBAD_BASE_W        13

// mask bit order inside the mask field (bit 5 down to bit 1)
`define FBAD_CLS_CPU       3'h4
`define FBAD_CLS_SUP_CODE  3'h3
`define FBAD_CLS_SUP_DATA  3'h2
`define FBAD_CLS_USR_CODE  3'h1
`define FBAD_CLS_USR_DATA  3'h0

// defined bits: base, back door enable, write protect, masks, enable
`define FBAD_DEF_MASK      32'hFFF8033F
`define FBAD_RESET_VAL     32'h00000000

// back-door window offset from the peripheral base register
`define FBAD_BACKDOOR_OFS  32'h04000000

// chip mode straps that leave the flash enabled
`define FBAD_MODE_SINGLE   3'h6
`define FBAD_MODE_MASTER   3'h7
`define FBAD_MODE_EXT_OK   2'h0

// extra latency of back-door reads, in cycles
`define FBAD_BD_EXTRA      2

// edge after reset release, counted from zero, at which the enable is loaded
`define FBAD_LOAD_EDGE     2'h2

`endif

// ### hdl/fbad_delay.v
// fixed pipeline delay for back-door read selects
`timescale 1ns/10ps
module fbad_delay #(
  parameter DEPTH = 2
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  // data
  input  wire din,
  output wire dout
);
  reg [DEPTH-1:0] pipe_r;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_stage
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          pipe_r[i] <= 1'b0;
        else if (i == 0)
          pipe_r[i] <= din;
        else
          pipe_r[i] <= pipe_r[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate
  assign dout = pipe_r[DEPTH-1];
endmodule // fbad_delay

// ### hdl/fbad_top.v
// flash base address register with access decode and back-door window
//
// Function
// - core writes the register only by control register move; core cannot read it.
// - debug module may both read and write the register.
// - undefined bits ignore writes and read back zero to debug.
// - reset clears back door enable bit.
// - reset loads enable flag from chip mode; other bits left alone by that.
// - back-door reads complete two cycles later than direct reads.
// - enable resets set for config pin with 110, or 111 with mode lines 00.
// - default configuration boots single-chip with flash valid at address zero.
// - secured flash forces enable set regardless of chip configuration.
// - base field bits 31..19 place flash on any 512K boundary.
// - write protect bit 8 reads as one; direct-mapped writes to flash raise access error, back-door writes do not.
// - five mask bits block access classes; masked refs treated as non-flash.
// - enable bit set enables module; clear means no accesses claimed.
`timescale 1ns/10ps
`include "fbad_defs.vh"
module fbad_top #(
  parameter BD_EXTRA = `FBAD_BD_EXTRA
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // reset-time chip mode straps (pins)
  input  wire        reset_config_pin,
  input  wire [2:0]  mode_data,
  input  wire [1:0]  mode_ext,
  input  wire        flash_secured,
  // core control register move write
  input  wire        control_register_move,
  input  wire [31:0] core_wdata,
  // debug module access
  input  wire        dbg_wr,
  input  wire        dbg_rd,
  input  wire [31:0] dbg_wdata,
  output reg  [31:0] dbg_rdata,
  output reg         dbg_rvalid,
  // direct core access
  input  wire        acc_req,
  input  wire [31:0] acc_addr,
  input  wire        acc_write,
  input  wire        acc_cpu_space,
  input  wire        acc_super,
  input  wire        acc_code,
  output reg         flash_sel,
  output reg         access_error,
  // back-door access from other masters
  input  wire [31:0] peripheral_base_register,
  input  wire        bd_req,
  input  wire [31:0] bd_addr,
  input  wire        bd_write,
  output reg         bd_sel,
  output reg         bd_rd_done,
  // register state view
  output reg  [31:0] flash_base_address,
  output reg         back_door_enable
);
  // two-flop synchronisers for strap pins
  reg  [6:0]  strap_s1_r;
  reg  [6:0]  strap_s2_r;
  wire [6:0]  strap_in;
  wire        strap_cfg;
  wire [2:0]  strap_data;
  wire [1:0]  strap_ext;
  wire        strap_sec;
  wire        mode_en;

  // register state and next value
  reg         load_pend_r;
  reg  [31:0] fba_r;
  reg  [31:0] fba_nxt;
  wire [31:0] rd_view;

  // access decode
  reg  [2:0]  cls;
  wire [`FBAD_MASK_W-1:0] cls_hot;
  wire [`FBAD_MASK_W-1:0] cls_open;
  wire        cls_ok;
  wire        dir_hit;
  wire        bd_hit;
  wire        bd_rd_late;
  wire [31:0] bd_base;

  assign strap_in = {flash_secured, mode_ext, mode_data, reset_config_pin};

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_r <= 7'h00;
      strap_s2_r <= 7'h00;
    end
    else
    begin
      strap_s1_r <= strap_in;
      strap_s2_r <= strap_s1_r;
    end
  end

  // straps are caught a few cycles after release, once synchronised
  reg [1:0] load_cnt_r;
  assign {strap_sec, strap_ext, strap_data, strap_cfg} = strap_s2_r;
  assign mode_en = strap_sec
                 | (strap_cfg & (strap_data == `FBAD_MODE_SINGLE))
                 | (strap_cfg & (strap_data == `FBAD_MODE_MASTER)
                    & (strap_ext == `FBAD_MODE_EXT_OK));

  // register update: core move and debug writes share one path
  always @*
  begin
    fba_nxt = fba_r;
    // a write landing on the load edge is lost; software starts after it
    if (load_pend_r && load_cnt_r == `FBAD_LOAD_EDGE)
      fba_nxt[`FBAD_EN_BIT] = mode_en;
    else if (control_register_move)
      fba_nxt = core_wdata & `FBAD_DEF_MASK;
    else if (dbg_wr)
      fba_nxt = dbg_wdata & `FBAD_DEF_MASK;
    fba_nxt[`FBAD_WP_BIT] = 1'b1;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // base zero, back door disabled, enable decided after release
      fba_r       <= `FBAD_RESET_VAL;
      load_pend_r <= 1'b1;
      load_cnt_r  <= 2'h0;
    end
    else
    begin
      fba_r <= fba_nxt;
      if (load_pend_r)
      begin
        load_cnt_r <= load_cnt_r + 2'h1;
        if (load_cnt_r == `FBAD_LOAD_EDGE)
          load_pend_r <= 1'b0;
      end
    end
  end

  // access class decode
  always @*
  begin
    if (acc_cpu_space)
      cls = `FBAD_CLS_CPU;
    else if (acc_super)
      cls = acc_code ? `FBAD_CLS_SUP_CODE : `FBAD_CLS_SUP_DATA;
    else
      cls = acc_code ? `FBAD_CLS_USR_CODE : `FBAD_CLS_USR_DATA;
  end

  // one-hot class; bit n pairs with mask bit n+1
  genvar g;
  generate
    for (g = 0; g < `FBAD_MASK_W; g = g + 1)
    begin : g_cls
      assign cls_hot[g]  = ({29'h0, cls} == g);
      // a masked class falls through as a non-flash reference
      assign cls_open[g] = cls_hot[g] & ~fba_r[`FBAD_MASK_LSB + g];
    end
  endgenerate

  assign cls_ok = |cls_open;

  assign dir_hit = fba_r[`FBAD_EN_BIT]
                 & (acc_addr[`FBAD_BASE_MSB:`FBAD_BASE_LSB]
                    == fba_r[`FBAD_BASE_MSB:`FBAD_BASE_LSB])
                 & cls_ok;

  // back-door window, one 512K array starting at peripheral base plus offset
  assign bd_base = peripheral_base_register + `FBAD_BACKDOOR_OFS;
  assign bd_hit  = fba_r[`FBAD_EN_BIT]
                 & (bd_addr[`FBAD_BASE_MSB:`FBAD_BASE_LSB]
                    == bd_base[`FBAD_BASE_MSB:`FBAD_BASE_LSB]);

  fbad_delay #(
    .DEPTH (BD_EXTRA)
  ) u_bd_delay (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (bd_req & bd_hit & ~bd_write),
    .dout    (bd_rd_late)
  );

  // only the debug module reads; the core has no read port
  assign rd_view = fba_r & `FBAD_DEF_MASK;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_sel          <= 1'b0;
      access_error       <= 1'b0;
      bd_sel             <= 1'b0;
      bd_rd_done         <= 1'b0;
      dbg_rdata          <= 32'h00000000;
      dbg_rvalid         <= 1'b0;
      flash_base_address <= 32'h00000000;
      back_door_enable   <= 1'b0;
    end
    else
    begin
      // writes through the direct mapping are refused
      flash_sel    <= acc_req & dir_hit & ~acc_write;
      access_error <= acc_req & dir_hit & acc_write;
      bd_sel       <= bd_req & bd_hit;
      bd_rd_done   <= bd_rd_late;
      dbg_rvalid   <= dbg_rd;
      dbg_rdata    <= dbg_rd ? rd_view : 32'h00000000;
      flash_base_address <= fba_r;
      // mirror only; the back-door window does not look at this bit
      back_door_enable   <= fba_r[`FBAD_BACK_DOOR_EN_BIT];
    end
  end
endmodule // fbad_top

// ### verification/fbad_host.sv
// core, debug module and other master issuing one-cycle requests
`timescale 1ns/10ps
module fbad_host (
  // clock
  input  wire        sys_clk,
  // requests
  output reg         control_register_move = 1'b0,
  output reg  [31:0] core_wdata = 32'h0,
  output reg         dbg_wr = 1'b0,
  output reg         dbg_rd = 1'b0,
  output reg  [31:0] dbg_wdata = 32'h0,
  output reg         acc_req = 1'b0,
  output reg  [31:0] acc_addr = 32'h0,
  output reg         acc_write = 1'b0,
  output reg         acc_cpu_space = 1'b0,
  output reg         acc_super = 1'b0,
  output reg         acc_code = 1'b0,
  output reg         bd_req = 1'b0,
  output reg  [31:0] bd_addr = 32'h0,
  output reg         bd_write = 1'b0
);
  // k: 0 core write, 1 debug write, 2 debug read, 3 direct, 4 back door
  // the core never reads the register; it only writes it
  // callers set the enable before any flash access
  // other masters use the window at peripheral base plus 0x04000000
  task op(input [2:0] k, input [31:0] a, input [2:0] c, input w);
  begin
    @(negedge sys_clk);
    {core_wdata, dbg_wdata, acc_addr, bd_addr} = {4{a}};
    {acc_cpu_space, acc_super, acc_code} = c;
    acc_write = w;
    bd_write = w;
    {bd_req, acc_req, dbg_rd, dbg_wr, control_register_move} = 5'h01 << k;
    @(negedge sys_clk);
    {bd_req, acc_req, dbg_rd, dbg_wr, control_register_move} = 5'h00;
  end
  endtask
endmodule // fbad_host

// ### verification/fbad_top_properties.sv
// port assertions for the flash base address decode block
`timescale 1ns/10ps
module fbad_checker (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // debug, direct and back-door traffic
  input wire        dbg_rd,
  input wire        dbg_rvalid,
  input wire [31:0] dbg_rdata,
  input wire        acc_req,
  input wire        acc_write,
  input wire        flash_sel,
  input wire        access_error,
  input wire        bd_req,
  input wire        bd_write,
  input wire        bd_sel,
  input wire        bd_rd_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_ANSWER: assert property (dbg_rd |=> dbg_rvalid && $past(dbg_rd))
    else $error("debug read not answered");
  AST_RSVD_ZERO: assert property (dbg_rvalid |-> (dbg_rdata & 32'h0007FCC0) == 32'h0)
    else $error("reserved bits read non-zero");
  AST_WP_ONE: assert property (dbg_rvalid |-> dbg_rdata[8])
    else $error("write protect bit read clear");
  AST_IDLE_DATA: assert property (!dbg_rvalid |-> dbg_rdata == 32'h0)
    else $error("read data shown outside a read");
  AST_SEL_CAUSE: assert property (flash_sel |-> $past(acc_req && !acc_write))
    else $error("select without a read request");
  AST_ERR_CAUSE: assert property (access_error |-> $past(acc_req && acc_write))
    else $error("access error without a write");
  AST_BD_CAUSE: assert property (bd_sel |-> $past(bd_req))
    else $error("back-door hit without request");
  AST_BD_LATE: assert property (bd_rd_done |-> $past(bd_sel, 2) && !$past(bd_write, 3))
    else $error("back-door read done at wrong time");
endmodule // fbad_checker

bind fbad_top fbad_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .dbg_rd(dbg_rd),
  .dbg_rvalid(dbg_rvalid), .dbg_rdata(dbg_rdata), .acc_req(acc_req), .acc_write(acc_write),
  .flash_sel(flash_sel), .access_error(access_error), .bd_req(bd_req), .bd_write(bd_write),
  .bd_sel(bd_sel), .bd_rd_done(bd_rd_done));

// ### verification/testbench.sv
// self-checking bench for the flash base address decode block
`timescale 1ns/10ps
module testbench;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg reset_config_pin = 1'b0, flash_secured = 1'b0;
  reg [2:0] mode_data = 3'h0;
  reg [1:0] mode_ext = 2'h0;
  wire [31:0] peripheral_base_register = 32'h40000000;
  wire control_register_move, dbg_wr, dbg_rd, acc_req, acc_write, acc_cpu_space;
  wire acc_super, acc_code, bd_req, bd_write, dbg_rvalid, flash_sel, access_error;
  wire bd_sel, bd_rd_done, back_door_enable;
  wire [31:0] core_wdata, dbg_wdata, acc_addr, bd_addr, dbg_rdata, flash_base_address;
  integer n_mismatch = 0;
  integer comparisons = 0;
  fbad_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reset_config_pin(reset_config_pin),
    .mode_data(mode_data), .mode_ext(mode_ext), .flash_secured(flash_secured),
    .control_register_move(control_register_move), .core_wdata(core_wdata),
    .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
    .dbg_rvalid(dbg_rvalid), .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_cpu_space(acc_cpu_space), .acc_super(acc_super), .acc_code(acc_code),
    .flash_sel(flash_sel), .access_error(access_error),
    .peripheral_base_register(peripheral_base_register), .bd_req(bd_req), .bd_addr(bd_addr),
    .bd_write(bd_write), .bd_sel(bd_sel), .bd_rd_done(bd_rd_done),
    .flash_base_address(flash_base_address), .back_door_enable(back_door_enable));
  fbad_host i_host (.sys_clk(sys_clk), .control_register_move(control_register_move),
    .core_wdata(core_wdata), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_wdata(dbg_wdata),
    .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_cpu_space(acc_cpu_space), .acc_super(acc_super), .acc_code(acc_code),
    .bd_req(bd_req), .bd_addr(bd_addr), .bd_write(bd_write));
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // strap cases {pin, data, ext, secured, enable}; reset must clear bit 9 too
  task t_reset;
    integer i;
    reg [47:0] tbl;
    reg [7:0] e;
  begin
    tbl = 48'hE1F1F46003D0;
    for (i = 0; i < 6; i = i + 1)
    begin
      e = tbl[47 - 8 * i -: 8];
      {reset_config_pin, mode_data, mode_ext, flash_secured} = e[7:1];
      rst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      i_host.op(2, 32'h0, 3'h0, 1'b0);
      chk(dbg_rdata, {31'h80, e[0]});
      i_host.op(0, 32'hFFFFFFFF, 3'h0, 1'b0);
    end
    $display("t_reset done");
  end
  endtask
  task t_regs;
  begin
    i_host.op(1, 32'h0, 3'h0, 1'b0);
    i_host.op(2, 32'h0, 3'h0, 1'b0);
    chk(dbg_rdata, 32'h00000100);
    i_host.op(0, 32'hFFFFFFFF, 3'h0, 1'b0);
    i_host.op(2, 32'h0, 3'h0, 1'b0);
    chk({31'h0, dbg_rvalid}, 32'h1);
    chk(dbg_rdata, 32'hFFF8033F);
    chk(flash_base_address, 32'hFFF8033F);
    chk({31'h0, back_door_enable}, 32'h1);
    $display("t_regs done");
  end
  endtask
  // one class masked per pass; class code j matches mask bit j+1
  task t_decode;
    integer c, j;
  begin
    for (c = 0; c < 5; c = c + 1)
    begin
      i_host.op(0, 32'h00080001 | (32'h2 << c), 3'h0, 1'b0);
      for (j = 0; j < 5; j = j + 1)
      begin
        i_host.op(3, 32'h00081234, j[2:0], 1'b0);
        chk({31'h0, flash_sel}, {31'h0, j != c});
      end
    end
    i_host.op(3, 32'h00100000, 3'h0, 1'b0);
    chk({31'h0, flash_sel}, 32'h0);
    i_host.op(3, 32'h00080000, 3'h0, 1'b1);
    chk({30'h0, access_error, flash_sel}, 32'h2);
    i_host.op(0, 32'h00080000, 3'h0, 1'b0);
    i_host.op(3, 32'h00080000, 3'h0, 1'b0);
    chk({31'h0, flash_sel}, 32'h0);
    $display("t_decode done");
  end
  endtask
  task t_backdoor;
  begin
    i_host.op(0, 32'h00080001, 3'h0, 1'b0);
    i_host.op(4, 32'h44000010, 3'h0, 1'b0);
    chk({30'h0, bd_sel, bd_rd_done}, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, bd_rd_done}, 32'h0);
    @(negedge sys_clk);
    chk({31'h0, bd_rd_done}, 32'h1);
    i_host.op(4, 32'h45000010, 3'h0, 1'b0);
    chk({31'h0, bd_sel}, 32'h0);
    $display("t_backdoor done");
  end
  endtask
  task print_verdict;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // hang guard: far beyond the under two hundred cycles the run needs
  initial
  begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial
  begin
    t_reset;
    t_regs;
    t_decode;
    t_backdoor;
    print_verdict;
  end
endmodule // testbench
